// >>> verilog/cdc_rate_mode_map.svh
// register map, field positions, modes and conversion-time table of the rate/mode block
`ifndef CDC_RATE_MODE_MAP_SVH
`define CDC_RATE_MODE_MAP_SVH

`define RATE_MODE_ADDR 8'h0A
`define RATE_MODE_RESET 8'hA0

`define VT_FILT_HI 7
`define VT_FILT_LO 6
`define CAP_FILT_HI 5
`define CAP_FILT_LO 3
`define MODE_HI 2
`define MODE_LO 0

`define MODE_IDLE 3'h0
`define MODE_CONT 3'h1
`define MODE_SINGLE 3'h2
`define MODE_PDOWN 3'h3
`define MODE_CAL_OFFSET 3'h5
`define MODE_CAL_GAIN 3'h6

// timing base: conversion times are held in tenths of a millisecond
`define TENTH_MS_NS 100000
`define SYS_CLK_PERIOD_NS 10

// voltage/temperature times, tenths of ms, chopping on
`define VT_TIME_0 12'h0C9
`define VT_TIME_1 12'h141
`define VT_TIME_2 12'h26D
`define VT_TIME_3 12'h4C5

// capacitance times, tenths of ms (110, 119, 200, 380, 620, 770, 920, 1096)
`define CAP_TIME_0 12'h06E
`define CAP_TIME_1 12'h077
`define CAP_TIME_2 12'h0C8
`define CAP_TIME_3 12'h17C
`define CAP_TIME_4 12'h26C
`define CAP_TIME_5 12'h302
`define CAP_TIME_6 12'h398
`define CAP_TIME_7 12'h448

`define PRE_W 16
`define TICK_W 12

`endif

// >>> verilog/cdc_rate_mode_pkg.sv
// types of the rate/mode configuration block
`include "cdc_rate_mode_map.svh"

package cdc_rate_mode_pkg;

  typedef enum logic [1:0] {
    ph_idle,
    ph_cap,
    ph_vt,
    ph_down
  } phase_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rd_data;
    phase_t phase;
    logic [`PRE_W-1:0] pre;
    logic [`TICK_W-1:0] tick;
    logic [1:0] act_vt;
    logic [2:0] act_cap;
    logic [2:0] act_mode;
    logic act_halve;
    logic pending;
    logic conv_done;
    logic done_vt;
  } state_t;

endpackage

// >>> verilog/cdc_config_rate_mode.sv
// update-rate and operating-mode register with conversion-cycle timer
`timescale 1ns/1ps
`include "cdc_rate_mode_map.svh"

module cdc_config_rate_mode
  import cdc_rate_mode_pkg::*;
#(
  parameter logic [`PRE_W-1:0] TICK_CYCLES = `PRE_W'(`TENTH_MS_NS / `SYS_CLK_PERIOD_NS)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic clock_halve,
  input wire logic vt_chop_enable,
  input wire logic enable_a,
  output logic vt_filter_sel_hi,
  output logic vt_filter_sel_lo,
  output logic cap_filter_sel_2,
  output logic cap_filter_sel_1,
  output logic cap_filter_sel_0,
  output logic op_mode_sel_2,
  output logic op_mode_sel_1,
  output logic op_mode_sel_0,
  output logic converting_cap,
  output logic converting_vt,
  output logic conv_done,
  output logic conv_done_vt,
  output logic power_down,
  output logic cal_offset_active,
  output logic cal_gain_active
);

  state_t st;
  state_t next_st;
  logic busy;
  logic fin;
  logic [`TICK_W-1:0] limit;
  logic [`TICK_W-1:0] tenths;

  function automatic logic [`TICK_W-1:0] vt_time(input logic [1:0] code);
    case (code)
      2'h0: vt_time = `VT_TIME_0;
      2'h1: vt_time = `VT_TIME_1;
      2'h2: vt_time = `VT_TIME_2;
      default: vt_time = `VT_TIME_3;
    endcase
  endfunction

  function automatic logic [`TICK_W-1:0] cap_time(input logic [2:0] code);
    case (code)
      3'h0: cap_time = `CAP_TIME_0;
      3'h1: cap_time = `CAP_TIME_1;
      3'h2: cap_time = `CAP_TIME_2;
      3'h3: cap_time = `CAP_TIME_3;
      3'h4: cap_time = `CAP_TIME_4;
      3'h5: cap_time = `CAP_TIME_5;
      3'h6: cap_time = `CAP_TIME_6;
      default: cap_time = `CAP_TIME_7;
    endcase
  endfunction

  assign busy = (st.phase == ph_cap) || (st.phase == ph_vt);
  assign tenths = (st.phase == ph_vt) ? vt_time(st.act_vt) : cap_time(st.act_cap);
  // longest doubled figure still fits twelve bits
  assign limit = st.act_halve ? {tenths[`TICK_W-2:0], 1'b0} : tenths;
  assign fin = busy && (st.pre == TICK_CYCLES - `PRE_W'(1)) && (st.tick == limit - `TICK_W'(1));

  always_comb begin
    next_st = st;
    next_st.conv_done = 1'b0;
    next_st.rd_data = (reg_addr == `RATE_MODE_ADDR) ? st.cfg : 8'h00;
    case (st.phase)
      ph_idle: begin
        if (st.cfg[`MODE_HI:`MODE_LO] == `MODE_PDOWN) begin
          next_st.phase = ph_down;
        end else if (st.cfg[`MODE_HI:`MODE_LO] == `MODE_CONT || st.pending) begin
          // settings are sampled here, vt filter and clock_halve again at the cap-to-vt switch, never mid-conversion
          next_st.pending = 1'b0;
          next_st.phase = ph_cap;
          next_st.pre = '0;
          next_st.tick = '0;
          next_st.act_mode = st.cfg[`MODE_HI:`MODE_LO];
          next_st.act_cap = st.cfg[`CAP_FILT_HI:`CAP_FILT_LO];
          next_st.act_vt = st.cfg[`VT_FILT_HI:`VT_FILT_LO];
          next_st.act_halve = clock_halve;
        end
      end
      ph_cap, ph_vt: begin
        if (st.pre == TICK_CYCLES - `PRE_W'(1)) begin
          next_st.pre = '0;
          next_st.tick = st.tick + `TICK_W'(1);
        end else begin
          next_st.pre = st.pre + `PRE_W'(1);
        end
        if (fin) begin
          next_st.conv_done = 1'b1;
          next_st.done_vt = (st.phase == ph_vt);
          next_st.pre = '0;
          next_st.tick = '0;
          if (st.phase == ph_cap &&
              (st.act_mode == `MODE_CONT || st.act_mode == `MODE_SINGLE)) begin
            next_st.phase = ph_vt;
            next_st.act_vt = st.cfg[`VT_FILT_HI:`VT_FILT_LO];
            next_st.act_halve = clock_halve;
          end else begin
            next_st.phase = ph_idle;
          end
        end
      end
      ph_down: begin
        if (st.cfg[`MODE_HI:`MODE_LO] != `MODE_PDOWN) begin
          next_st.phase = ph_idle;
        end
      end
      default: begin
        next_st.phase = ph_idle;
      end
    endcase
    // a write after the start clear wins, so a request in the start cycle is kept
    if (reg_wr && reg_addr == `RATE_MODE_ADDR) begin
      next_st.cfg = reg_wdata;
      if (reg_wdata[`MODE_HI:`MODE_LO] == `MODE_SINGLE ||
          reg_wdata[`MODE_HI:`MODE_LO] == `MODE_CAL_OFFSET ||
          reg_wdata[`MODE_HI:`MODE_LO] == `MODE_CAL_GAIN) begin
        next_st.pending = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.cfg <= `RATE_MODE_RESET;
      st.phase <= ph_idle;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rd_data;
  assign vt_filter_sel_hi = st.cfg[`VT_FILT_HI];
  assign vt_filter_sel_lo = st.cfg[`VT_FILT_LO];
  assign cap_filter_sel_2 = st.cfg[`CAP_FILT_HI];
  assign cap_filter_sel_1 = st.cfg[`CAP_FILT_HI-1];
  assign cap_filter_sel_0 = st.cfg[`CAP_FILT_LO];
  assign op_mode_sel_2 = st.cfg[`MODE_HI];
  assign op_mode_sel_1 = st.cfg[`MODE_HI-1];
  assign op_mode_sel_0 = st.cfg[`MODE_LO];
  assign converting_cap = (st.phase == ph_cap);
  assign converting_vt = (st.phase == ph_vt);
  assign conv_done = st.conv_done;
  assign conv_done_vt = st.done_vt;
  assign power_down = (st.phase == ph_down);
  assign cal_offset_active = busy && (st.act_mode == `MODE_CAL_OFFSET);
  assign cal_gain_active = busy && (st.act_mode == `MODE_CAL_GAIN);

  // helper logic read only by the checks below
  int run_cnt;
  logic seen_write;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_cnt <= 0;
      seen_write <= 1'b0;
    end else begin
      run_cnt <= (busy && !fin) ? run_cnt + 1 : 0;
      seen_write <= seen_write || (reg_wr && reg_addr == `RATE_MODE_ADDR);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  reset_value_a: assert property (!seen_write |-> st.cfg == `RATE_MODE_RESET)
    else $error("config register left its reset value without a write");
  field_latch_a: assert property ((st.phase == ph_idle) ##1 (st.phase == ph_cap)
      |-> st.act_cap == $past(st.cfg[`CAP_FILT_HI:`CAP_FILT_LO])
      && st.act_mode == $past(st.cfg[`MODE_HI:`MODE_LO]))
    else $error("cap filter or mode not taken from the register fields");
  vt_time_a: assert property (fin && st.phase == ph_vt && !st.act_halve
      |-> run_cnt + 1 == int'(vt_time(st.act_vt)) * int'(TICK_CYCLES))
    else $error("vt conversion length wrong");
  halve_time_a: assert property (fin && st.act_halve
      |-> run_cnt + 1 == 2 * int'(tenths) * int'(TICK_CYCLES))
    else $error("halved clock conversion not twice as long");
  cap_time_a: assert property (fin && st.phase == ph_cap && !st.act_halve
      |-> run_cnt + 1 == int'(cap_time(st.act_cap)) * int'(TICK_CYCLES))
    else $error("cap conversion length wrong");
  power_down_a: assert property (st.phase == ph_idle && st.cfg[`MODE_HI:`MODE_LO] == `MODE_PDOWN
      |=> power_down)
    else $error("power-down mode not entered");
  single_stop_a: assert property (fin && st.phase == ph_vt && st.act_mode == `MODE_SINGLE
      ##1 st.cfg[`MODE_HI:`MODE_LO] == `MODE_SINGLE && !st.pending
      |=> st.phase == ph_idle)
    else $error("single conversion did not stop");
  write_read_a: assert property (reg_wr && reg_addr == `RATE_MODE_ADDR
      ##1 (reg_addr == `RATE_MODE_ADDR && !reg_wr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read does not return last written value");
  hold_busy_a: assert property (busy && !fin |=> $stable(st.act_cap) && $stable(st.act_vt))
    else $error("filter setting changed mid-conversion");

  cont_cover_c: cover property (fin && st.phase == ph_vt && st.act_mode == `MODE_CONT);
  single_cover_c: cover property (conv_done && conv_done_vt && st.act_mode == `MODE_SINGLE);
  cal_cover_c: cover property (fin && cal_offset_active);
  down_cover_c: cover property ($rose(power_down));

endmodule

// >>> tb/cdc_host_model.sv
// host model driving the register pointer/strobe port
`timescale 1ns/1ps
module cdc_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // a slow host leaves up to two idle cycles before an access
  task automatic gap();
    repeat ($urandom_range(2)) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    gap();
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    // released data must not look like the last value
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    gap();
    @(negedge sys_clk);
    reg_addr = a;
    repeat (2) @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// >>> tb/cdc_config_rate_mode_tb.sv
// self-checking bench of the rate/mode block against a table model
`timescale 1ns/1ps
module cdc_config_rate_mode_tb;
  import cdc_rate_mode_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clock_halve = 1'b0;
  logic vt_chop_enable = 1'b1;
  logic enable_a = 1'b0;
  logic [1:0] flags = 2'h0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, fld;
  wire reg_wr, converting_cap, converting_vt, conv_done, conv_done_vt;
  wire power_down, cal_offset_active, cal_gain_active;
  int err_count = 0;
  int n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  cdc_config_rate_mode #(.TICK_CYCLES(16'h0002)) i_cdc_config_rate_mode (
    .sys_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .clock_halve, .vt_chop_enable, .enable_a,
    .vt_filter_sel_hi(fld[7]), .vt_filter_sel_lo(fld[6]), .cap_filter_sel_2(fld[5]),
    .cap_filter_sel_1(fld[4]), .cap_filter_sel_0(fld[3]), .op_mode_sel_2(fld[2]),
    .op_mode_sel_1(fld[1]), .op_mode_sel_0(fld[0]), .converting_cap, .converting_vt,
    .conv_done, .conv_done_vt, .power_down, .cal_offset_active, .cal_gain_active);
  cdc_host_model i_cdc_host_model (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // length in cycles of the next cap (vt=0) or vt (vt=1) conversion
  task automatic span(input bit vt, output int n);
    int w;
    w = 0;
    n = 0;
    while ((vt ? converting_vt : converting_cap) !== 1'b1) begin
      w++;
      if (w > 40) begin
        err_count++;
        summarize();
      end
      @(negedge sys_clk);
    end
    flags = {cal_offset_active, cal_gain_active};
    while ((vt ? converting_vt : converting_cap) === 1'b1 && n < 9000) begin
      n++;
      @(negedge sys_clk);
    end
    if (n >= 9000) begin
      err_count++;
      summarize();
    end
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] cfg;
    int n;
    int h;
    int cap_t[8] = '{110, 119, 200, 380, 620, 770, 920, 1096};
    int vt_t[4] = '{201, 321, 621, 1221};
    void'($urandom(43462));
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    check("reset fields", fld, 8'hA0);
    i_cdc_host_model.rd(8'h0A, d);
    check("reset read", d, 8'hA0);
    i_cdc_host_model.wr(8'h0B, 8'h5A);
    i_cdc_host_model.rd(8'h0B, d);
    check("other read", d, 8'h00);
    i_cdc_host_model.rd(8'h0A, d);
    check("kept", d, 8'hA0);
    for (int i = 0; i < 4; i++) begin
      cfg = 8'($urandom) & 8'hF8;
      i_cdc_host_model.wr(8'h0A, cfg);
      check("fields", fld, cfg);
      i_cdc_host_model.rd(8'h0A, d);
      check("readback", d, cfg);
    end
    for (int i = 0; i < 6; i++) begin
      h = i % 2;
      clock_halve = h[0];
      vt_chop_enable = 1'($urandom);
      enable_a = 1'($urandom);
      i_cdc_host_model.wr(8'h0A, {2'(i % 4), 3'(i), 3'h2});
      span(0, n);
      check("cap time", n, cap_t[i] * 2 * (h + 1));
      check("cap end", {conv_done, conv_done_vt, converting_vt}, 3'b101);
      span(1, n);
      check("vt time", n, vt_t[i % 4] * 2 * (h + 1));
      check("vt end", {conv_done, conv_done_vt}, 2'b11);
    end
    clock_halve = 1'b0;
    i_cdc_host_model.wr(8'h0A, 8'h01);
    // second write lands inside the first cap conversion, so the vt count below is whole
    i_cdc_host_model.wr(8'h0A, 8'h09);
    span(0, n);
    span(1, n);
    check("cont vt", n, 402);
    span(0, n);
    check("next cap", n, 238);
    i_cdc_host_model.wr(8'h0A, 8'h03);
    span(1, n);
    repeat (3) @(negedge sys_clk);
    check("power down", {power_down, converting_cap}, 2'b10);
    for (int m = 5; m < 7; m++) begin
      i_cdc_host_model.wr(8'h0A, 8'(m));
      span(0, n);
      check("cal time", n, 220);
      check("cal flag", flags, (m == 5) ? 2'b10 : 2'b01);
    end
    summarize();
  end
endmodule
